// [hdl/usr_pkg.sv]
package usr_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int STAGES = 4;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int FIFO_DEPTH = 4;
    localparam int CNT_W = 16;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_COUNT = 4'h8;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_OVR_CLR_BIT = 1;
    localparam int ST_STAGE_LSB = 0;
    localparam int ST_PEND_BIT = 4;
    localparam int ST_OVR_BIT = 5;
    localparam int ST_FULL_BIT = 6;
    localparam int ST_EMPTY_BIT = 7;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic CTRL_EN_RST = 1'b1;
    localparam logic [3:0] STAGE_RST = 4'h0;
    localparam logic [15:0] COUNT_RST = 16'h0000;

    // ****************************************
    // next content of the four stages
    // ****************************************
    function automatic logic [3:0] next_stages(
        input logic load,
        input logic j,
        input logic k_n,
        input logic [3:0] par,
        input logic [3:0] cur
    );
        logic first;
        first = (j & ~cur[0]) | (k_n & cur[0]);
        if (load) begin
            next_stages = par;
        end else begin
            next_stages = {cur[2:0], first};
        end
    endfunction

endpackage

// [hdl/usr_top.sv]
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps

// ****************************************
// snapshot fifo
// ****************************************
module usr_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 4
) (
    input wire logic ref_clk, // system clock
    input wire logic rst, // async reset
    input wire logic in_valid, // push request
    output logic in_ready, // room left
    input wire logic [WIDTH-1:0] in_data, // pushed word
    output logic out_valid, // word available
    input wire logic out_ready, // pop request
    output logic [WIDTH-1:0] out_data, // oldest word
    output logic full, // no room
    output logic empty // nothing held
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [PW:0] count_reg;
    logic push;
    logic pop;

    assign full = (count_reg == (PW+1)'(DEPTH));
    assign empty = (count_reg == '0);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

endmodule // usr_fifo

// Operation
// R1 - stages change only on shift clock rise
// R2 - load select high loads parallel inputs
// R3 - load select low shifts right one stage
// R4 - equal serial inputs give D-type entry
// R5 - J high, K_n low toggles stage zero
// R6 - J low, K_n high holds stage zero
// R7 - polarity select gives true or inverted outputs
// R8 - master clear asynchronously zeroes all stages
// R9 - driver treats K input as active low
// R10 - polarity never alters stages; stage three dropped
module usr_top #(
    parameter int STAGES = usr_pkg::STAGES,
    parameter int FIFO_DEPTH = usr_pkg::FIFO_DEPTH
) (
    input wire logic ref_clk, // system clock, 40 MHz
    input wire logic rst, // async reset, active high
    input wire logic shift_clock, // stage clock, sampled on ref_clk
    input wire logic load_select, // 1 = parallel load, 0 = shift
    input wire logic [3:0] parallel_in, // parallel data
    input wire logic ser_j, // first stage J, active high
    input wire logic ser_k_n, // first stage K, active low
    input wire logic true_comp, // 1 = true outputs, 0 = inverted
    input wire logic master_clear, // async clear of stages
    output logic [3:0] stage_out, // buffered stage outputs
    output logic [3:0] snap_data, // stage snapshot after update
    output logic snap_valid, // snapshot available
    input wire logic snap_ready, // snapshot taken
    input wire logic [3:0] reg_addr, // register byte address
    input wire logic [31:0] reg_wdata, // register write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [31:0] reg_rdata // read data, cycle after strobe
);

    // ****************************************
    // edge capture
    // ****************************************
    logic clk_prev_reg;
    logic rise;
    logic pend_reg;
    logic cap_load_reg;
    logic cap_j_reg;
    logic cap_k_n_reg;
    logic [3:0] cap_par_reg;
    logic apply;
    logic [3:0] stage_reg;
    logic [3:0] stage_next;
    logic en_reg;
    logic ovr_reg;
    logic [15:0] count_reg;
    logic fifo_in_ready;
    logic fifo_full;
    logic fifo_empty;
    logic ctrl_wr;

    assign rise = shift_clock && !clk_prev_reg;
    // the fifo stalls the update, so no applied update loses its snapshot; a rise while one waits is lost
    assign apply = pend_reg && fifo_in_ready;
    assign ctrl_wr = reg_wr && (reg_addr == usr_pkg::OFS_CTRL);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            clk_prev_reg <= 1'b0;
        end else begin
            clk_prev_reg <= shift_clock;
        end
    end

    // inputs are frozen at the edge; a stalled update still uses them
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cap_load_reg <= 1'b0;
            cap_j_reg <= 1'b0;
            cap_k_n_reg <= 1'b0;
            cap_par_reg <= usr_pkg::STAGE_RST;
        end else if (rise && en_reg && !pend_reg) begin
            cap_load_reg <= load_select;
            cap_j_reg <= ser_j;
            cap_k_n_reg <= ser_k_n;
            cap_par_reg <= parallel_in;
        end
    end

    // clear also drops an update still waiting
    always_ff @(posedge ref_clk or posedge rst or posedge master_clear) begin
        if (rst || master_clear) begin
            pend_reg <= 1'b0;
        end else if (rise && en_reg && !pend_reg) begin
            pend_reg <= 1'b1; // R1
        end else if (apply) begin
            pend_reg <= 1'b0;
        end
    end

    // ****************************************
    // stages
    // ****************************************
    assign stage_next = usr_pkg::next_stages(cap_load_reg, cap_j_reg, cap_k_n_reg,
                                             cap_par_reg, stage_reg); // R2 R3 R4 R5 R6 R9

    always_ff @(posedge ref_clk or posedge rst or posedge master_clear) begin
        if (rst || master_clear) begin
            stage_reg <= usr_pkg::STAGE_RST; // R8
        end else if (apply) begin
            stage_reg <= stage_next; // R1 R10
        end
    end

    assign stage_out = true_comp ? stage_reg : ~stage_reg; // R7 R10

    usr_fifo #(
        .WIDTH(STAGES),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_valid(apply),
        .in_ready(fifo_in_ready),
        .in_data(stage_next),
        .out_valid(snap_valid),
        .out_ready(snap_ready),
        .out_data(snap_data),
        .full(fifo_full),
        .empty(fifo_empty)
    );

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            en_reg <= usr_pkg::CTRL_EN_RST;
        end else if (ctrl_wr) begin
            en_reg <= reg_wdata[usr_pkg::CTRL_EN_BIT];
        end
    end

    // an edge lost while one waits sets the flag; set wins over clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ovr_reg <= 1'b0;
        end else if (rise && en_reg && pend_reg) begin
            ovr_reg <= 1'b1;
        end else if (ctrl_wr && reg_wdata[usr_pkg::CTRL_OVR_CLR_BIT]) begin
            ovr_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count_reg <= usr_pkg::COUNT_RST;
        end else if (reg_wr && (reg_addr == usr_pkg::OFS_COUNT)) begin
            count_reg <= reg_wdata[15:0];
        end else if (apply) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                usr_pkg::OFS_CTRL: begin
                    reg_rdata <= {31'h00000000, en_reg};
                end
                usr_pkg::OFS_STATUS: begin
                    reg_rdata <= {24'h000000, fifo_empty, fifo_full, ovr_reg,
                                  pend_reg, stage_reg};
                end
                usr_pkg::OFS_COUNT: begin
                    reg_rdata <= {16'h0000, count_reg};
                end
                default: begin
                    reg_rdata <= 32'h00000000;
                end
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    AST_ONLY_ON_APPLY: assert property ( // R1
        @(posedge ref_clk) disable iff (rst || master_clear)
        !apply |=> $stable(stage_reg))
        else $error("stages changed without a shift clock rise");

    AST_EDGE_TO_APPLY: assert property ( // R1
        @(posedge ref_clk) disable iff (rst || master_clear)
        rise && en_reg && !pend_reg && !fifo_full |=> apply)
        else $error("shift clock rise not applied next cycle");

    AST_LOAD: assert property ( // R2
        @(posedge ref_clk) disable iff (rst || master_clear)
        apply && cap_load_reg |=> stage_reg == $past(cap_par_reg))
        else $error("parallel load did not copy the inputs");

    AST_SHIFT: assert property ( // R3
        @(posedge ref_clk) disable iff (rst || master_clear)
        apply && !cap_load_reg |=> stage_reg[3:1] == $past(stage_reg[2:0]))
        else $error("shift did not move stages right");

    AST_D_ENTRY: assert property ( // R4
        @(posedge ref_clk) disable iff (rst || master_clear)
        apply && !cap_load_reg && (cap_j_reg == cap_k_n_reg)
        |=> stage_reg[0] == $past(cap_j_reg))
        else $error("D-type entry wrong");

    AST_TOGGLE: assert property ( // R5
        @(posedge ref_clk) disable iff (rst || master_clear)
        apply && !cap_load_reg && cap_j_reg && !cap_k_n_reg
        |=> stage_reg[0] != $past(stage_reg[0]))
        else $error("toggle mode did not invert stage zero");

    AST_HOLD: assert property ( // R6
        @(posedge ref_clk) disable iff (rst || master_clear)
        apply && !cap_load_reg && !cap_j_reg && cap_k_n_reg
        |=> stage_reg[0] == $past(stage_reg[0]))
        else $error("hold mode changed stage zero");

    AST_POLARITY: assert property ( // R7
        @(posedge ref_clk) disable iff (rst)
        stage_out == (true_comp ? stage_reg : ~stage_reg))
        else $error("outputs do not follow polarity select");

    AST_CLEAR: assert property ( // R8
        @(posedge ref_clk) disable iff (rst)
        master_clear |-> (stage_reg == 4'h0) && (stage_out == {4{~true_comp}}))
        else $error("master clear did not clear stages");

    // a clear that ends beside a polarity change still moves the stages
    AST_POL_NO_STORE: assert property ( // R10
        @(posedge ref_clk) disable iff (rst || master_clear)
        $changed(true_comp) && !$past(apply) && !master_clear && !$past(master_clear)
        |-> $stable(stage_reg))
        else $error("polarity change altered stages");

    AST_TRUE_OUT: assert property ( // R7
        @(posedge ref_clk) disable iff (rst)
        true_comp |-> stage_out == stage_reg)
        else $error("true polarity output differs from stages");

    AST_COMP_OUT: assert property ( // R7
        @(posedge ref_clk) disable iff (rst)
        !true_comp |-> stage_out == ~stage_reg)
        else $error("complement output is not inverted");

    AST_CLEAR_DROPS: assert property ( // R8
        @(posedge ref_clk) disable iff (rst)
        master_clear |-> !pend_reg && !apply)
        else $error("master clear left an update pending");

    AST_NO_ENABLE: assert property ( // R1
        @(posedge ref_clk) disable iff (rst || master_clear)
        rise && !en_reg && !pend_reg |=> !pend_reg)
        else $error("disabled shift clock rise was taken");

    AST_LOST_EDGE: assert property ( // R1
        @(posedge ref_clk) disable iff (rst)
        rise && en_reg && pend_reg |=> ovr_reg)
        else $error("lost shift clock rise did not flag overrun");

    AST_CAP_HELD: assert property ( // R2
        @(posedge ref_clk) disable iff (rst)
        pend_reg |=> $stable({cap_load_reg, cap_j_reg, cap_k_n_reg, cap_par_reg}))
        else $error("captured inputs moved while an update waits");

    AST_EDGE_CAPTURE: assert property ( // R2
        @(posedge ref_clk) disable iff (rst)
        rise && en_reg && !pend_reg |=> {cap_load_reg, cap_j_reg, cap_k_n_reg, cap_par_reg}
        == $past({load_select, ser_j, ser_k_n, parallel_in}))
        else $error("inputs not captured at the shift clock rise");

    AST_FULL_STALL: assert property ( // R1
        @(posedge ref_clk) disable iff (rst || master_clear)
        pend_reg && fifo_full |=> $stable(stage_reg))
        else $error("stages changed while the snapshot fifo was full");

    AST_SNAP_EQ_STAGE: assert property ( // R2 R3
        @(posedge ref_clk) disable iff (rst || master_clear)
        apply && fifo_empty |=> snap_data == stage_reg)
        else $error("snapshot differs from the updated stages");

endmodule // usr_top

// [tb/usr_src.sv]
`timescale 1ns/1ps

// ****************************************
// upstream logic making one stage clock pulse per request
// ****************************************
module usr_src (
    input wire logic ref_clk, // system clock
    input wire logic rst, // async reset
    input wire logic go, // start one pulse
    input wire logic [1:0] mode, // {j, k_n} for the first stage
    output logic shift_clock, // pulse, two cycles high
    output logic ser_j, // first stage J
    output logic ser_k_n, // first stage K, active low
    output logic busy // pulse in progress
);
    logic [2:0] cnt_reg;

    assign busy = (cnt_reg != 3'h0);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 3'h0;
            shift_clock <= 1'b0;
            ser_j <= 1'b0;
            ser_k_n <= 1'b0;
        end else begin
            if (go) begin
                cnt_reg <= 3'h5;
                ser_j <= mode[1];
                // hold mode is k_n high, toggle is k_n low
                ser_k_n <= mode[0];
            end else if (busy) begin
                cnt_reg <= cnt_reg - 3'h1;
            end
            shift_clock <= (cnt_reg == 3'h4) || (cnt_reg == 3'h3);
        end
    end
endmodule // usr_src

// [tb/testbench.sv]
`timescale 1ns/1ps

module testbench;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic load_select = 1'b0;
    logic [3:0] parallel_in = 4'h0;
    logic true_comp = 1'b1;
    logic master_clear = 1'b0;
    logic snap_ready = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic go = 1'b0;
    logic [1:0] jk = 2'h0;
    logic shift_clock, ser_j, ser_k_n, busy, snap_valid;
    logic [3:0] stage_out, snap_data;
    logic [31:0] reg_rdata;
    int n_mismatch = 0;
    int n_tests = 0;

    always #12.5 ref_clk = ~ref_clk;

    usr_src i_src (.ref_clk(ref_clk), .rst(rst), .go(go), .mode(jk),
        .shift_clock(shift_clock), .ser_j(ser_j), .ser_k_n(ser_k_n), .busy(busy));

    usr_top i_dut (.ref_clk(ref_clk), .rst(rst), .shift_clock(shift_clock),
        .load_select(load_select), .parallel_in(parallel_in), .ser_j(ser_j),
        .ser_k_n(ser_k_n), .true_comp(true_comp), .master_clear(master_clear),
        .stage_out(stage_out), .snap_data(snap_data), .snap_valid(snap_valid),
        .snap_ready(snap_ready), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic pulse(input logic ld, input logic [3:0] par, input logic [1:0] sj);
        int n;
        @(posedge ref_clk);
        load_select <= ld;
        parallel_in <= par;
        jk <= sj;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        #1;
        n = 0;
        while (busy === 1'b1 && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
        // update lands one edge after the sampled rise
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_modes();
        logic [1:0] sj [5] = '{2'h0, 2'h3, 2'h0, 2'h2, 2'h1};
        logic [3:0] exp [5] = '{4'hA, 4'h5, 4'hA, 4'h5, 4'hB};
        for (int i = 0; i < 5; i++) begin
            pulse(i == 0, 4'hA, sj[i]);
            check("stage_out mode", exp[i], stage_out);
        end
        @(posedge ref_clk);
        true_comp <= 1'b0;
        load_select <= 1'b1;
        parallel_in <= 4'h0;
        repeat (4) @(posedge ref_clk);
        #1;
        check("stage_out comp", 4'h4, stage_out);
        @(posedge ref_clk);
        true_comp <= 1'b1;
        @(negedge ref_clk);
        check("stage_out true", 4'hB, stage_out);
    endtask

    task automatic t_clear();
        logic [31:0] d;
        pulse(1'b1, 4'hF, 2'h0);
        @(posedge ref_clk);
        master_clear <= 1'b1;
        @(negedge ref_clk);
        check("stage_out clear", 4'h0, stage_out);
        @(posedge ref_clk);
        true_comp <= 1'b0;
        @(negedge ref_clk);
        check("stage_out clear comp", 4'hF, stage_out);
        @(posedge ref_clk);
        master_clear <= 1'b0;
        true_comp <= 1'b1;
        reg_read(4'h8, d);
        check("count", 32'h6, d);
    endtask

    task automatic t_regs();
        logic [31:0] d;
        reg_read(4'h0, d);
        check("ctrl reset", 32'h1, d);
        reg_read(4'hC, d);
        check("unmapped read", 32'h0, d);
        reg_write(4'hC, 32'hFFFF_FFFF);
        reg_write(4'h0, 32'h0);
        pulse(1'b1, 4'h3, 2'h0);
        check("stage_out disabled", 4'h0, stage_out);
        reg_write(4'h0, 32'h1);
        reg_read(4'h0, d);
        check("ctrl back", 32'h1, d);
    endtask

    task automatic t_fifo();
        logic [31:0] d;
        @(posedge ref_clk);
        snap_ready <= 1'b0;
        // four fill the fifo, the fifth waits, the sixth is lost
        for (int i = 1; i <= 6; i++) begin
            pulse(1'b1, 4'(i), 2'h0);
        end
        reg_read(4'h4, d);
        check("status lost edge", 32'h74, d & 32'hFF);
        reg_write(4'h0, 32'h3);
        reg_read(4'h4, d);
        check("status full", 32'h54, d & 32'hFF);
        @(posedge ref_clk);
        snap_ready <= 1'b1;
        // one pop per edge while ready stays high
        for (int i = 1; i <= 5; i++) begin
            @(negedge ref_clk);
            check("snap_valid", 32'h1, 32'(snap_valid));
            check("snap_data", 32'(i), 32'(snap_data));
        end
        repeat (3) @(negedge ref_clk);
        check("snap_valid drained", 32'h0, 32'(snap_valid));
        check("stage_out last", 4'h5, stage_out);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #75000;
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        check("stage_out reset", 4'h0, stage_out);
        check("snap_valid reset", 32'h0, 32'(snap_valid));
        t_modes();
        t_clear();
        t_regs();
        t_fifo();
        report_and_stop();
    end
endmodule // testbench
